// ===== include/cia_consts.svh
// offsets, field positions, reset values and timing counts of the char input channel
`ifndef CIA_CONSTS_SVH
`define CIA_CONSTS_SVH
// register byte addresses
`define CIA_REG_CTRL    5'h00
`define CIA_REG_STATUS  5'h04
`define CIA_REG_WORD    5'h08
`define CIA_REG_WCNT    5'h0C
`define CIA_REG_ACNT    5'h10
// control fields
`define CIA_CTRL_CODE_LSB  0
`define CIA_CTRL_CPW_LSB   6
`define CIA_CTRL_ILV_BIT   8
// status fields
`define CIA_ST_ERR_BIT     0
`define CIA_ST_RDY_BIT     1
`define CIA_ST_ACT_BIT     2
`define CIA_ST_GAP_BIT     3
`define CIA_ST_DONE_BIT    4
`define CIA_ST_SIZE_LSB    5
`define CIA_ST_FF_LSB      7
// unit address codes
`define CIA_CODE_OFF       6'h00
`define CIA_CODE_OFF_DIR   6'h20
`define CIA_CODE_PT1       6'h04
`define CIA_CODE_PT2       6'h05
`define CIA_UA_DIR_BIT     5
`define CIA_UA_TAPE_BIT    3
// reset values
`define CIA_RST_CPW        2'h0
// timing: one machine cycle, and where T8 falls in it
`define CIA_CLK_NS         20
`define CIA_MCYC_NS        80
`define CIA_MCYC_CLKS      (`CIA_MCYC_NS / `CIA_CLK_NS)
`define CIA_T8_PHASE       (`CIA_MCYC_CLKS / 2)
`endif

// ===== include/cia_pkg.sv
// types shared by the char input channel
package cia_pkg;
  // character size, gray along 6 -> 12 -> 24
  typedef enum logic [1:0] {
    CIA_SZ6  = 2'h0,
    CIA_SZ12 = 2'h1,
    CIA_SZ24 = 2'h3
  } cia_size_e;
endpackage : cia_pkg

// ===== logic/cia_channel.sv
// character-serial input channel with word assembly and wishbone registers
//
// How it works
// - a 24-bit word assembly register hands whole words to the processor
// - characters are 6, 12 or 24 bits plus parity; four, two or one per word
// - at most one size line asserted; none asserted means 6-bit characters
// - transfers are paced by the peripheral character clock and by the processor taking each word
// - unit codes 00 and 40 both disconnect the channel
// - code 40 keeps the direction bit set; code 00 clears it
// - remaining 62 codes split by direction bit into 31 input, 31 output
// - magnetic tape bit selects a modified terminate condition
// - paper-tape input with all-zero data and parity raises gap indication
// - interlace: word counter down per word, address counter up per access
// - init command loads unit address and presets character counter
// - unit address outputs are all false while the channel is inactive
// - active-low data lines are inverted before strobing
// - odd parity checked after strobe; mismatch sets readable error flag
// - clock idles high; low sets clock-detect at T8 with precess clear
// - input data strobed while clock-detect set, precess clear, input direction
// - precess set at T0 after clock returns high with clock-detect set
// - at T8 with precess and buffer ready, shift flip-flop sets
// - after shift, T0 clears shift, precess, clock-detect and char register together
// - buffer ready is false while processor has not taken previous word
// - full word clears buffer-full; an early word read stalls until then
// - a new clock before the previous character shifted sets error
`timescale 1ns/10ps
`include "cia_consts.svh"

module cia_channel
  import cia_pkg::*;
#(
  parameter int MCYC = `CIA_MCYC_CLKS  // clocks per machine cycle
) (
  input  wire logic        clk_i,            // 50 MHz system clock
  input  wire logic        rst_i,            // synchronous reset, active high
  // wishbone classic slave
  input  wire logic        cyc_i,            // bus cycle
  input  wire logic        stb_i,            // strobe
  input  wire logic        we_i,             // write enable
  input  wire logic [4:2]  adr_i,            // word address
  input  wire logic [3:0]  sel_i,            // byte selects
  input  wire logic [31:0] dat_i,            // write data
  output logic      [31:0] dat_o,            // read data
  output logic             ack_o,            // acknowledge
  // peripheral link
  input  wire logic        char_clk_i,       // character clock, idles high
  input  wire logic [23:0] char_in_n_i,      // data lines, active low
  input  wire logic        parity_in_n_i,    // parity line, active low
  input  wire logic        size12_i,         // 12-bit size select
  input  wire logic        size24_i,         // 24-bit size select
  input  wire logic        parity_inh_n_i,   // low disables parity check
  output logic      [5:0]  unit_addr_o       // unit address lines
);

  localparam int PW = 29;  // synchronised pin bits
  localparam int T8P = MCYC / 2;

  // three-stage pin synchroniser with agreement filter
  // stage one may go metastable, so nothing but stage two reads it
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [PW-1:0] pin_s3;
  logic [PW-1:0] pin_f;
  wire  [PW-1:0] pin_raw = {parity_inh_n_i, size24_i, size12_i,
                            parity_in_n_i, char_in_n_i, char_clk_i};
  wire  [PW-1:0] pin_agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge clk_i) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // a bit follows only once stages two and three agree
  // a one-cycle glitch never reaches the sequence, at the price of one
  // more clock of latency on every link line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_f <= {1'b1, 2'b00, 1'b1, 24'hFFFFFF, 1'b1};  // idle levels: no false clock or size after reset
    end else begin
      pin_f <= (pin_s3 & pin_agree) | (pin_f & ~pin_agree);
    end
  end

  wire        clk_low   = ~pin_f[0];
  wire [23:0] data_true = ~pin_f[24:1];
  wire        par_true  = ~pin_f[25];
  wire        sz12      = pin_f[26];
  wire        sz24      = pin_f[27];
  wire        par_en    = pin_f[28];

  // character size from the link lines
  cia_size_e size;
  assign size = sz24 ? CIA_SZ24 : (sz12 ? CIA_SZ12 : CIA_SZ6);

  // machine cycle divider giving T0 and T8 pulses
  // every sequence step but the data strobe waits for one of these pulses,
  // so the clock line is looked at once per phase; a clock phase shorter than one
  // machine cycle can be missed altogether; the synchroniser delay only shifts it
  logic [7:0] phase;
  wire        last_ph = (phase == 8'(MCYC - 1));
  wire        t0      = (phase == 8'h00);
  wire        t8      = (phase == 8'(T8P));

  always_ff @(posedge clk_i) begin
    if (rst_i || last_ph) begin
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
  end

  // channel state
  logic [5:0]  unit_address_register;
  logic        active;
  logic [1:0]  cpw;
  logic        ilv;
  logic [1:0]  char_cnt;
  logic        clock_detect_ff;
  logic        precess_detect_ff;
  logic        shift_control_ff;
  logic [23:0] single_character_register;
  logic        char_par;
  logic [23:0] word_assembly_register;
  logic        word_ready;
  logic        err;
  logic        gap;
  logic        done;
  logic [14:0] word_cnt;
  logic [14:0] addr_cnt;

  wire direction_bit  = unit_address_register[`CIA_UA_DIR_BIT];
  wire tape_unit_bit  = unit_address_register[`CIA_UA_TAPE_BIT];
  wire is_input       = active & ~direction_bit;
  wire shift_gate_term = is_input;
  wire buffer_full_flag = ~word_ready;

  // characters per word, clipped to what the size allows
  // used at init and again at every word reload, so one decoder serves both
  function automatic logic [1:0] cia_cpw_max(input cia_size_e s,
                                             input logic [1:0] want);
    logic [1:0] lim;
    lim = 2'h3;
    if (s == CIA_SZ12) begin
      lim = 2'h1;
    end else if (s == CIA_SZ24) begin
      lim = 2'h0;
    end
    cia_cpw_max = (want > lim) ? lim : want;
  endfunction : cia_cpw_max

  // size-masked view of the data lines
  // bits above the selected size never reach the char register
  wire [23:0] size_mask = (size == CIA_SZ24) ? 24'hFFFFFF :
                          (size == CIA_SZ12) ? 24'h000FFF : 24'h00003F;
  wire [23:0] char_now  = data_true & size_mask;

  // odd parity and gap tests on the held character
  // judged as precess sets, in the last cycle the register still follows the lines
  wire par_bad   = ~(^{single_character_register, char_par});
  wire all_zero  = (single_character_register == 24'h000000) & ~char_par;
  wire pt_code   = (unit_address_register == `CIA_CODE_PT1) |
                   (unit_address_register == `CIA_CODE_PT2);

  // sequence events
  // clock-detect, precess and shift advance in that order, each on its own
  // pulse; the character waits in the char register from precess until the
  // shift, which itself waits while the previous word is still untaken
  wire set_cd   = is_input & ~precess_detect_ff & clk_low & t8;
  wire strobe   = is_input & clock_detect_ff & ~precess_detect_ff;
  wire set_pr   = is_input & clock_detect_ff & ~precess_detect_ff &
                  ~clk_low & t0;
  wire set_sh   = precess_detect_ff & ~shift_control_ff & buffer_full_flag &
                  shift_gate_term & t8;
  wire end_sh   = shift_control_ff & t0;
  wire rate_err = precess_detect_ff & ~shift_control_ff & clk_low & t8 &
                  is_input;
  wire late_err = precess_detect_ff & ~shift_control_ff & word_ready &
                  shift_gate_term & t8;

  // wishbone decode
  // writes never wait; only a word read can stretch a cycle, and only while
  // an input unit is addressed, so a read of an idle channel cannot hang
  wire req      = cyc_i & stb_i;
  wire a_ctrl   = ({adr_i, 2'b00} == `CIA_REG_CTRL);
  wire a_stat   = ({adr_i, 2'b00} == `CIA_REG_STATUS);
  wire a_word   = ({adr_i, 2'b00} == `CIA_REG_WORD);
  wire a_wcnt   = ({adr_i, 2'b00} == `CIA_REG_WCNT);
  wire a_acnt   = ({adr_i, 2'b00} == `CIA_REG_ACNT);
  wire any_sel  = |sel_i;
  // a word read waits for a full word while input is running
  wire word_rd  = req & ~we_i & a_word;
  wire stall    = word_rd & is_input & ~word_ready;
  wire take     = req & ~ack_o & ~stall;
  wire wr       = take & we_i & any_sel;
  wire wr_ctrl  = wr & a_ctrl;
  wire wr_stat  = wr & a_stat;
  wire wd_take  = take & word_rd & word_ready;
  wire [5:0] new_code = dat_i[`CIA_CTRL_CODE_LSB +: 6];
  wire new_off  = (new_code == `CIA_CODE_OFF) |
                  (new_code == `CIA_CODE_OFF_DIR);

  // interlace terminate: tape stays addressed, others disconnect
  wire last_wd  = wd_take & ilv & (word_cnt == 15'h0001);
  wire term_off = last_wd & ~tape_unit_bit;

  // ack one cycle, dropped the cycle after
  // one wait state on every access keeps the read path registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= take;
    end
  end

  // read data mux
  // unmapped offsets read as zero and ignore writes
  wire [31:0] stat_word = {22'h0, shift_control_ff, precess_detect_ff,
                           clock_detect_ff, size, done, gap, active,
                           word_ready, err};
  wire [31:0] rd_mux = a_ctrl ? {23'h0, ilv, cpw, unit_address_register} :
                       a_stat ? stat_word :
                       a_word ? {8'h00, word_assembly_register} :
                       a_wcnt ? {17'h0, word_cnt} :
                       a_acnt ? {17'h0, addr_cnt} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (take && !we_i) begin
      dat_o <= rd_mux;
    end
  end

  // unit address register and activity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_address_register <= 6'h00;
      active <= 1'b0;
      cpw    <= `CIA_RST_CPW;
      ilv    <= 1'b0;
    end else if (wr_ctrl) begin
      unit_address_register <= new_code;
      active <= ~new_off;
      cpw    <= dat_i[`CIA_CTRL_CPW_LSB +: 2];
      ilv    <= dat_i[`CIA_CTRL_ILV_BIT];
    end else if (term_off) begin
      unit_address_register <= 6'h00;
      active <= 1'b0;
    end
  end

  // lines stay false while inactive, even after code 40
  // registered, so the peripheral decodes an address free of glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_addr_o <= 6'h00;
    end else begin
      unit_addr_o <= active ? unit_address_register : 6'h00;
    end
  end

  // clock-detect, precess and shift flip-flops
  // an init write or a disconnect clears them, so a character cut off
  // mid-way leaves nothing half taken behind
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_ctrl || !active) begin
      clock_detect_ff   <= 1'b0;
      precess_detect_ff <= 1'b0;
      shift_control_ff  <= 1'b0;
    end else if (end_sh) begin
      clock_detect_ff   <= 1'b0;
      precess_detect_ff <= 1'b0;
      shift_control_ff  <= 1'b0;
    end else begin
      if (set_cd) begin
        clock_detect_ff <= 1'b1;
      end
      if (set_pr) begin
        precess_detect_ff <= 1'b1;
      end
      if (set_sh) begin
        shift_control_ff <= 1'b1;
      end
    end
  end

  // character register: follows lines until precess, cleared after shift
  always_ff @(posedge clk_i) begin
    if (rst_i || end_sh || wr_ctrl) begin
      single_character_register <= 24'h000000;
      char_par <= 1'b0;
    end else if (strobe) begin
      single_character_register <= char_now;
      char_par <= par_true;
    end
  end

  // word assembly: shift new character in at the low end
  // the word restarts from zero, so a short word carries no old bits
  wire [23:0] war_next = (size == CIA_SZ24) ? single_character_register :
                         (size == CIA_SZ12) ?
                           {word_assembly_register[11:0], single_character_register[11:0]} :
                           {word_assembly_register[17:0], single_character_register[5:0]};
  wire last_char = (char_cnt == 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_assembly_register <= 24'h000000;
    end else if (end_sh) begin
      word_assembly_register <= war_next;
    end else if (wr_ctrl || wd_take) begin
      word_assembly_register <= 24'h000000;
    end
  end

  // character counter and word-ready; ready means buffer-full cleared
  // a reload re-clips the stored count to the size now on the lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      char_cnt   <= `CIA_RST_CPW;
      word_ready <= 1'b0;
    end else if (wr_ctrl) begin
      char_cnt   <= cia_cpw_max(size, dat_i[`CIA_CTRL_CPW_LSB +: 2]);
      word_ready <= 1'b0;
    end else if (end_sh) begin
      char_cnt   <= last_char ? cia_cpw_max(size, cpw) : char_cnt - 2'h1;
      word_ready <= last_char;
    end else if (wd_take) begin
      word_ready <= 1'b0;
    end
  end

  // sticky flags; a hardware set wins over a software clear
  // err is shared by parity, rate and late-read faults, so software
  // cannot tell them apart from the flag alone
  wire st_clr_err  = wr_stat & dat_i[`CIA_ST_ERR_BIT];
  wire st_clr_gap  = wr_stat & dat_i[`CIA_ST_GAP_BIT];
  wire st_clr_done = wr_stat & dat_i[`CIA_ST_DONE_BIT];
  wire set_perr    = set_pr & par_en & par_bad;
  wire set_gap     = set_pr & pt_code & all_zero;
  wire set_err     = set_perr | rate_err | late_err;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err  <= 1'b0;
      gap  <= 1'b0;
      done <= 1'b0;
    end else begin
      err  <= set_err | (err & ~st_clr_err);
      gap  <= set_gap | (gap & ~st_clr_gap);
      done <= last_wd | (done & ~st_clr_done);
    end
  end

  // interlace counters: down per word, up per memory access
  // one bus access per cycle, so a load and a count never meet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_cnt <= 15'h0000;
      addr_cnt <= 15'h0000;
    end else if (wr & a_wcnt) begin
      word_cnt <= dat_i[14:0];
    end else if (wr & a_acnt) begin
      addr_cnt <= dat_i[14:0];
    end else if (wd_take && ilv) begin
      word_cnt <= word_cnt - 15'h0001;
      addr_cnt <= addr_cnt + 15'h0001;
    end
  end

endmodule : cia_channel

// ===== tb/cia_channel_monitor.sv
// port-level assertions for the char input channel
`timescale 1ns/10ps
module cia_monitor (
  input wire logic        clk_i,       // system clock
  input wire logic        rst_i,       // sync reset
  input wire logic        cyc_i,       // bus cycle
  input wire logic        stb_i,       // strobe
  input wire logic        we_i,        // write enable
  input wire logic [4:2]  adr_i,       // word address
  input wire logic [3:0]  sel_i,       // byte selects
  input wire logic [31:0] dat_i,       // write data
  input wire logic [31:0] dat_o,       // read data
  input wire logic        ack_o,       // acknowledge
  input wire logic        char_clk_i,  // char clock
  input wire logic        size12_i,    // size select
  input wire logic        size24_i,    // size select
  input wire logic [5:0]  unit_addr_o  // unit address
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // decoded bus events, named once for all properties
  wire req     = cyc_i && stb_i && !ack_o;
  wire wr_ctrl = ack_o && cyc_i && we_i && adr_i == 3'h0 && sel_i != 4'h0;
  wire rd_ack  = ack_o && !we_i;

  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");
  a_write_ack_next: assert property (req && we_i |=> ack_o) else $error("write not acked");
  a_read_ack_next: assert property (req && !we_i && adr_i != 3'h2 |=> ack_o) else $error("read not acked");
  a_unmapped_zero: assert property (rd_ack && adr_i > 3'h4 |-> dat_o == 32'h0) else $error("unmapped read");
  a_init_loads_addr: assert property (wr_ctrl && dat_i[4:0] != 5'h0 |=> unit_addr_o == $past(dat_i[5:0]))
    else $error("unit address not loaded");
  a_disconnect_codes: assert property (wr_ctrl && dat_i[4:0] == 5'h0 |=> unit_addr_o == 6'h00)
    else $error("disconnect code left address");
  a_idle_after_reset: assert property ($past(rst_i) |-> unit_addr_o == 6'h00) else $error("address after reset");
  a_size_field: assert property (rd_ack && adr_i == 3'h1 && $past(size12_i, 6) == size12_i
    && $past(size24_i, 6) == size24_i |-> dat_o[6:5] == {size24_i, size12_i | size24_i})
    else $error("size field wrong");
  a_active_flag: assert property (rd_ack && adr_i == 3'h1 |-> dat_o[2] == (unit_addr_o != 6'h00))
    else $error("active flag disagrees");
  c_word_read: cover property (rd_ack && adr_i == 3'h2);
  c_disconnect: cover property (wr_ctrl && dat_i[4:0] == 5'h0);
  c_char_frame: cover property ($fell(char_clk_i));
endmodule : cia_monitor

bind cia_channel cia_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .char_clk_i, .size12_i, .size24_i, .unit_addr_o);

// ===== tb/cia_periph.sv
// peripheral coupler model: sends characters on its own char clock
`timescale 1ns/10ps
module cia_periph (
  input  wire logic        clk_i,       // system clock
  output logic             char_clk_o,  // char clock, idles high
  output logic      [23:0] char_n_o,    // data lines, active low
  output logic             par_n_o,     // parity line, active low
  output logic             size12_o,    // 12-bit select
  output logic             size24_o,    // 24-bit select
  output logic             inh_n_o      // low skips parity check
);
  // quiet lines at time zero
  initial begin
    char_clk_o = 1'b1;
    char_n_o   = 24'hFFFFFF;
    par_n_o    = 1'b1;
    size12_o   = 1'b0;
    size24_o   = 1'b0;
    inh_n_o    = 1'b1;
  end
  // format select; 24 loses to 12 so two lines never rise together
  task automatic setup(input logic s12, input logic s24, input logic inh);
    @(posedge clk_i);
    size12_o <= s12;
    size24_o <= s24 & ~s12;
    inh_n_o  <= inh;
    repeat (8) @(posedge clk_i);
  endtask : setup
  // one character, one machine cycle per clock phase
  task automatic send(input logic [23:0] d, input logic bad);
    @(posedge clk_i);
    char_n_o   <= ~d;
    par_n_o    <= ~(~^d ^ bad);
    char_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    char_clk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    // hold time over: lines stop showing the character
    char_n_o <= ~char_n_o;
    par_n_o  <= ~par_n_o;
    repeat (8) @(posedge clk_i);
  endtask : send
endmodule : cia_periph

// ===== tb/testbench.sv
// self-checking bench for the char input channel
`timescale 1ns/10ps
module testbench;
  import cia_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, char_clk, par_n, s12, s24, inh_n;
  logic [4:2]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [23:0] char_n;
  logic [5:0]  unit_addr;
  int          err_total, checks;

  cia_channel #(.MCYC(4)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .char_clk_i(char_clk), .char_in_n_i(char_n), .parity_in_n_i(par_n), .size12_i(s12), .size24_i(s24),
    .parity_inh_n_i(inh_n), .unit_addr_o(unit_addr));
  cia_periph per (.clk_i, .char_clk_o(char_clk), .char_n_o(char_n), .par_n_o(par_n), .size12_o(s12),
    .size24_o(s24), .inh_n_o(inh_n));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // one classic cycle; read data taken at the edge that sees ack
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a[4:2];
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 3000);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      err_total++;
      test_done();
    end
    @(posedge clk_i);
  endtask : bus

  task automatic t_reset;
    check("unit address", {26'h0, unit_addr}, 32'h0);
    bus(1'b0, 5'h04, 32'h0);
    check("status", rd, 32'h0);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("reset test done");
  endtask : t_reset

  // four 6-bit chars; the word read is issued early and must stall
  task automatic t_word6;
    bus(1'b1, 5'h00, 32'h0C1);
    check("unit address", {26'h0, unit_addr}, 32'h01);
    fork
      bus(1'b0, 5'h08, 32'h0);
      begin
        per.send(24'h21, 1'b0);
        per.send(24'h3F, 1'b0);
        per.send(24'h00, 1'b0);
        per.send(24'h15, 1'b0);
      end
    join
    check("word", rd, 32'h87F015);
    bus(1'b0, 5'h04, 32'h0);
    check("status", rd, 32'h04);
    $display("word6 test done");
  endtask : t_word6

  task automatic t_parity;
    per.send(24'h07, 1'b1);
    bus(1'b0, 5'h04, 32'h0);
    check("parity error", rd & 32'h1, 32'h1);
    bus(1'b1, 5'h04, 32'h1);
    per.setup(1'b0, 1'b0, 1'b0);
    per.send(24'h07, 1'b1);
    bus(1'b0, 5'h04, 32'h0);
    check("inhibited", rd & 32'h1, 32'h0);
    per.setup(1'b0, 1'b0, 1'b1);
    $display("parity test done");
  endtask : t_parity

  // 12-bit then 24-bit characters, data inverted on the lines
  task automatic t_sizes;
    per.setup(1'b1, 1'b0, 1'b1);
    bus(1'b1, 5'h00, 32'h041);
    fork
      bus(1'b0, 5'h08, 32'h0);
      begin
        per.send(24'hABC, 1'b0);
        per.send(24'h123, 1'b0);
      end
    join
    check("word 12", rd, 32'hABC123);
    bus(1'b0, 5'h04, 32'h0);
    check("size 12", rd & 32'h60, 32'h20);
    per.setup(1'b0, 1'b1, 1'b1);
    bus(1'b1, 5'h00, 32'h001);
    fork
      bus(1'b0, 5'h08, 32'h0);
      per.send(24'h5A0F3C, 1'b0);
    join
    check("word 24", rd, 32'h5A0F3C);
    bus(1'b0, 5'h04, 32'h0);
    check("size 24", rd & 32'h60, 32'h60);
    per.setup(1'b0, 1'b0, 1'b1);
    $display("sizes test done");
  endtask : t_sizes

  // second char arrives while the first word is still untaken
  task automatic t_late;
    bus(1'b1, 5'h00, 32'h001);
    per.send(24'h11, 1'b0);
    per.send(24'h22, 1'b0);
    bus(1'b0, 5'h04, 32'h0);
    check("late error", rd & 32'h3, 32'h3);
    bus(1'b0, 5'h08, 32'h0);
    check("held word", rd, 32'h11);
    bus(1'b0, 5'h08, 32'h0);
    check("next word", rd, 32'h22);
    bus(1'b1, 5'h04, 32'h1);
    $display("late test done");
  endtask : t_late

  task automatic t_codes;
    logic [5:0] c [4] = '{6'h00, 6'h20, 6'h21, 6'h0B};
    foreach (c[i]) begin
      bus(1'b1, 5'h00, {26'h0, c[i]});
      check("unit address", {26'h0, unit_addr}, (c[i][4:0] == 5'h0) ? 32'h0 : {26'h0, c[i]});
      bus(1'b0, 5'h00, 32'h0);
      check("direction", rd & 32'h20, {26'h0, c[i]} & 32'h20);
      bus(1'b0, 5'h04, 32'h0);
      check("active", rd & 32'h4, (c[i][4:0] == 5'h0) ? 32'h0 : 32'h4);
    end
    $display("codes test done");
  endtask : t_codes

  task automatic t_gap_ilv;
    per.setup(1'b0, 1'b0, 1'b0);
    bus(1'b1, 5'h00, 32'h004);
    per.send(24'h0, 1'b1);
    bus(1'b0, 5'h04, 32'h0);
    check("gap", rd & 32'h8, 32'h8);
    per.setup(1'b0, 1'b0, 1'b1);
    bus(1'b1, 5'h00, 32'h101);
    bus(1'b1, 5'h0C, 32'h5);
    bus(1'b1, 5'h10, 32'h7FFE);
    per.send(24'h2A, 1'b0);
    bus(1'b0, 5'h08, 32'h0);
    check("word", rd, 32'h2A);
    bus(1'b0, 5'h0C, 32'h0);
    check("word count", rd, 32'h4);
    bus(1'b0, 5'h10, 32'h0);
    check("address count", rd, 32'h7FFF);
    bus(1'b1, 5'h0C, 32'h1);
    per.send(24'h15, 1'b0);
    bus(1'b0, 5'h08, 32'h0);
    check("last word", rd, 32'h15);
    check("non-tape disconnect", {26'h0, unit_addr}, 32'h0);
    bus(1'b1, 5'h00, 32'h10B);
    bus(1'b1, 5'h0C, 32'h1);
    per.send(24'h15, 1'b0);
    bus(1'b0, 5'h08, 32'h0);
    check("tape stays", {26'h0, unit_addr}, 32'h0B);
    bus(1'b0, 5'h04, 32'h0);
    check("done and active", rd & 32'h14, 32'h14);
    $display("gap and interlace test done");
  endtask : t_gap_ilv

  initial begin
    err_total = 0;
    checks = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 3'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_word6();
    t_parity();
    t_sizes();
    t_late();
    t_codes();
    t_gap_ilv();
    test_done();
  end
endmodule : testbench
